/* File: logic/mcu_exec_alu.sv */
// Data path of one instruction: value, destination and flag effects.
// Assumes the caller applies the result and owns all state.
`timescale 1ns/10ps
`default_nettype none
`include "mcu_exec_map.svh"
module mcu_exec_alu (
    input  wire logic                   carry,
    input  wire logic                   half_carry,
    input  wire logic [7:0]             working,
    input  wire logic [7:0]             operand,
    input  wire logic [7:0]             imm,
    input  wire mcu_exec_pkg::op_t      op,
    output mcu_exec_pkg::exec_res_t     res
);

    // ***
    // Operation select
    // ***
    // Only the fields an opcode names are raised; all else stays quiet.
    always_comb begin
        logic [4:0] lo;
        logic [4:0] hi;
        logic       nibble_carry_internal;
        lo = {1'b0, working[3:0]};
        hi = {1'b0, working[7:4]};
        nibble_carry_internal = 1'b0;
        res = '0;
        unique case (op)
            mcu_exec_pkg::complement_in_place: begin
                res.value = ~operand;
                res.to_mem = 1'b1;
                res.set_zero = 1'b1;
            end
            mcu_exec_pkg::complement_to_working: begin
                res.value = ~operand;
                res.to_working = 1'b1;
                res.set_zero = 1'b1;
            end
            mcu_exec_pkg::decimal_adjust_op: begin
                if (lo > `BCD_LIMIT || half_carry) begin
                    lo = lo + `BCD_FIX;
                end
                nibble_carry_internal = lo[4];
                hi = hi + {4'h0, nibble_carry_internal};
                if (hi > `BCD_LIMIT || carry) begin
                    hi = hi + `BCD_FIX;
                    res.carry = 1'b1;
                end else begin
                    res.carry = carry;
                end
                res.value = {hi[3:0], lo[3:0]};
                res.to_mem = 1'b1;
                res.set_carry = 1'b1;
            end
            mcu_exec_pkg::minus_one_op, mcu_exec_pkg::minus_one_to_working: begin
                res.value = operand - 8'h01;
                res.to_mem = (op == mcu_exec_pkg::minus_one_op);
                res.to_working = !res.to_mem;
                res.set_zero = 1'b1;
            end
            mcu_exec_pkg::plus_one_op, mcu_exec_pkg::plus_one_to_working: begin
                res.value = operand + 8'h01;
                res.to_mem = (op == mcu_exec_pkg::plus_one_op);
                res.to_working = !res.to_mem;
                res.set_zero = 1'b1;
            end
            mcu_exec_pkg::copy_mem_to_working: begin
                res.value = operand;
                res.to_working = 1'b1;
            end
            mcu_exec_pkg::copy_imm_to_working, mcu_exec_pkg::pop_back_imm_op: begin
                res.value = imm;
                res.to_working = 1'b1;
            end
            mcu_exec_pkg::copy_working_to_mem: begin
                res.value = working;
                res.to_mem = 1'b1;
            end
            mcu_exec_pkg::union_mem_to_working, mcu_exec_pkg::union_into_mem_op: begin
                res.value = working | operand;
                res.to_mem = (op == mcu_exec_pkg::union_into_mem_op);
                res.to_working = !res.to_mem;
                res.set_zero = 1'b1;
            end
            mcu_exec_pkg::union_imm_to_working: begin
                res.value = working | imm;
                res.to_working = 1'b1;
                res.set_zero = 1'b1;
            end
            mcu_exec_pkg::rotate_left_op, mcu_exec_pkg::rotate_left_working: begin
                res.value = {operand[6:0], operand[7]};
                res.to_mem = (op == mcu_exec_pkg::rotate_left_op);
                res.to_working = !res.to_mem;
            end
            mcu_exec_pkg::rotate_left_via_carry,
            mcu_exec_pkg::rotate_left_via_carry_working: begin
                res.value = {operand[6:0], carry};
                res.carry = operand[7];
                res.set_carry = 1'b1;
                res.to_mem = (op == mcu_exec_pkg::rotate_left_via_carry);
                res.to_working = !res.to_mem;
            end
            default: begin
                res = '0;
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: logic/mcu_exec_core.sv */
// Execute block of an 8-bit core: runs one instruction per command write.
// Assumes a single AHB-Lite master; data memory and stack live here.
//
// Overview of operation
// - Both preclear ops executed: watchdog zero, time-out and power-down flags clear.
// - Only one preclear op executed: just record it, counter and flags unchanged.
// - Complement in place inverts the memory byte, writes back, updates zero only.
// - Complement to working puts inverted byte in working register, zero only.
// - Decimal adjust: low nibble above 9 or half carry adds 6, makes nibble carry.
// - High nibble plus nibble carry above 9 or carry adds 6, sets carry; to memory.
// - Decrement writes byte minus one to memory or working register, zero only.
// - Increment writes byte plus one to memory or working register, zero only.
// - Power-down stops execution, keeps RAM and registers, PC plus one.
// - Power-down clears watchdog and prescaler, sets power-down, clears time-out.
// - Direct branch loads PC from the instruction, no flag touched.
// - Move immediate loads the 8-bit constant into working register, no flags.
// - Moves between working register and memory copy the byte, no flags.
// - No-operation only advances the program counter by one.
// - OR of working register with memory or immediate, result placed, zero only.
// - Plain return reloads PC from stack top over two cycles, no flags.
// - Return with constant also loads the immediate into the working register.
// - Interrupt return reloads PC and sets global interrupt enable.
// - Rotate left in place moves bit 7 into bit 0, no flags.
// - Rotate left to working writes only the working register, no flags.
// - Rotate through carry rotates byte and carry as nine bits.
// - Old carry enters bit 0, old bit 7 becomes carry; only carry changes.
`timescale 1ns/10ps
`default_nettype none
`include "mcu_exec_map.svh"
module mcu_exec_core #(
    parameter int DMEM_DEPTH        = 32,
    parameter int STACK_DEPTH       = 4,
    parameter int PC_WIDTH          = 13,
    parameter int WATCHDOG_PRESCALE = `WATCHDOG_PRESCALE_DEFAULT
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [7:0]               working_register,
    output logic [PC_WIDTH-1:0]      program_counter,
    output logic                     global_interrupt_enable,
    output logic                     power_down_flag,
    output logic                     time_out_flag,
    output logic                     clock_stopped
);

    localparam int AW = $clog2(DMEM_DEPTH);
    localparam int SW = $clog2(STACK_DEPTH);

    // ***
    // State
    // ***
    typedef struct packed {
        mcu_exec_pkg::seq_t                   seq;
        mcu_exec_pkg::bus_phase_t             phase;
        logic [7:0]                           working_register;
        logic [PC_WIDTH-1:0]                  pc;
        logic                                 carry_flag;
        logic                                 half_carry_flag;
        logic                                 zero_flag;
        logic                                 time_out_flag;
        logic                                 power_down_flag;
        logic                                 global_interrupt_enable;
        logic                                 first_seen;
        logic                                 second_seen;
        logic [7:0]                           watchdog_counter;
        logic [15:0]                          prescaler;
        logic [AW-1:0]                        mem_addr;
        logic [DMEM_DEPTH-1:0][7:0]           dmem;
        logic [STACK_DEPTH-1:0][PC_WIDTH-1:0] stack;
        logic [SW:0]                          depth;
        logic [31:0]                          last_cmd;
    } state_t;

    state_t                  st;
    state_t                  next_st;
    mcu_exec_pkg::op_t       op;
    mcu_exec_pkg::exec_res_t res;
    logic [AW-1:0]           cmd_addr;
    logic [7:0]              cmd_imm;
    logic [SW-1:0]           top;

    // True when the captured data phase is a write to the given offset.
    function automatic logic hit_write(input mcu_exec_pkg::bus_phase_t p,
                                       input logic [4:0] ofs);
        hit_write = p.valid && p.write && (p.addr == ofs);
    endfunction

    // ***
    // Command fields
    // ***
    // Commands are decoded straight from hwdata in the write data phase.
    assign op       = mcu_exec_pkg::op_t'(hwdata[`CMD_OP_LSB +: 5]);
    assign cmd_addr = hwdata[`CMD_MADDR_LSB +: AW];
    assign cmd_imm  = hwdata[`CMD_IMM_LSB +: 8];
    assign top      = (st.depth == '0) ? '0 : SW'(st.depth - 1'b1);

    mcu_exec_alu u_alu (
        .carry      (st.carry_flag),
        .half_carry (st.half_carry_flag),
        .working    (st.working_register),
        .operand    (st.dmem[cmd_addr]),
        .imm        (cmd_imm),
        .op         (op),
        .res        (res)
    );

    // ***
    // Next state
    // ***
    // Order inside matters: register writes, then watchdog, then the
    // instruction, so that a watchdog set wins over a status write clear, and an instruction clear wins over it.
    always_comb begin
        logic tick;
        logic run;
        tick = 1'b0;
        run = 1'b0;
        next_st = st;

        // Address phase capture; this slave never stalls.
        next_st.phase.valid = hsel && hready && htrans[1];
        next_st.phase.write = hwrite;
        next_st.phase.addr  = haddr[4:0];

        // Plain register writes.
        if (hit_write(st.phase, `MAP_STATUS)) begin
            next_st.carry_flag = hwdata[`ST_CARRY];
            next_st.half_carry_flag = hwdata[`ST_HALF_CARRY];
            next_st.zero_flag = hwdata[`ST_ZERO];
            next_st.time_out_flag = hwdata[`ST_TIME_OUT];
            next_st.power_down_flag = hwdata[`ST_POWER_DOWN];
            next_st.global_interrupt_enable = hwdata[`ST_GIE];
            if (hwdata[`ST_WAKE] && st.seq == mcu_exec_pkg::seq_halt) begin
                next_st.seq = mcu_exec_pkg::seq_run;
            end
        end
        if (hit_write(st.phase, `MAP_WORKING)) begin
            next_st.working_register = hwdata[7:0];
        end
        if (hit_write(st.phase, `MAP_PC)) begin
            next_st.pc = hwdata[PC_WIDTH-1:0];
        end
        if (hit_write(st.phase, `MAP_MEM_ADDR)) begin
            next_st.mem_addr = hwdata[AW-1:0];
        end
        if (hit_write(st.phase, `MAP_MEM_DATA)) begin
            next_st.dmem[st.mem_addr] = hwdata[7:0];
        end
        // A push beyond the stack depth is dropped.
        if (hit_write(st.phase, `MAP_STACK) && st.depth != (SW+1)'(STACK_DEPTH)) begin
            next_st.stack[st.depth[SW-1:0]] = hwdata[PC_WIDTH-1:0];
            next_st.depth = st.depth + 1'b1;
        end

        // Watchdog keeps running while the clock is stopped, so it can wake the core.
        tick = (st.prescaler == 16'(WATCHDOG_PRESCALE - 1));
        next_st.prescaler = tick ? 16'h0000 : st.prescaler + 16'h0001;
        if (tick) begin
            next_st.watchdog_counter = st.watchdog_counter + 8'h01;
            if (st.watchdog_counter == `WATCHDOG_TOP) begin
                next_st.time_out_flag = 1'b1;
                if (st.seq == mcu_exec_pkg::seq_halt) begin
                    next_st.seq = mcu_exec_pkg::seq_run;
                end
            end
        end

        // Second cycle of every return.
        if (st.seq == mcu_exec_pkg::seq_pop) begin
            next_st.pc = st.stack[top];
            if (st.depth != '0) begin
                next_st.depth = st.depth - 1'b1;
            end
            next_st.seq = mcu_exec_pkg::seq_run;
        end

        // Instruction execution; refused while busy or stopped.
        run = hit_write(st.phase, `MAP_CMD) && st.seq == mcu_exec_pkg::seq_run;
        if (run) begin
            next_st.last_cmd = hwdata;
            next_st.pc = st.pc + 1'b1;
            if (res.to_working) begin
                next_st.working_register = res.value;
            end
            if (res.to_mem) begin
                next_st.dmem[cmd_addr] = res.value;
            end
            if (res.set_zero) begin
                next_st.zero_flag = (res.value == 8'h00);
            end
            if (res.set_carry) begin
                next_st.carry_flag = res.carry;
            end
            unique case (op)
                mcu_exec_pkg::first_preclear_op, mcu_exec_pkg::second_preclear_op: begin
                    if ((op == mcu_exec_pkg::first_preclear_op) ? st.second_seen
                                                                : st.first_seen) begin
                        next_st.watchdog_counter = `RST_WATCHDOG;
                        next_st.time_out_flag = 1'b0;
                        next_st.power_down_flag = 1'b0;
                        next_st.first_seen = 1'b0;
                        next_st.second_seen = 1'b0;
                    end else if (op == mcu_exec_pkg::first_preclear_op) begin
                        next_st.first_seen = 1'b1;
                    end else begin
                        next_st.second_seen = 1'b1;
                    end
                end
                mcu_exec_pkg::power_down_op: begin
                    next_st.seq = mcu_exec_pkg::seq_halt;
                    next_st.watchdog_counter = `RST_WATCHDOG;
                    next_st.prescaler = 16'h0000;
                    next_st.power_down_flag = 1'b1;
                    next_st.time_out_flag = 1'b0;
                end
                mcu_exec_pkg::direct_branch_op: begin
                    next_st.pc = hwdata[`CMD_IMM_LSB +: PC_WIDTH];
                end
                mcu_exec_pkg::pop_back_op, mcu_exec_pkg::pop_back_imm_op: begin
                    next_st.seq = mcu_exec_pkg::seq_pop;
                end
                mcu_exec_pkg::interrupt_exit_op: begin
                    next_st.seq = mcu_exec_pkg::seq_pop;
                    next_st.global_interrupt_enable = 1'b1;
                end
                default: begin
                    next_st.seq = mcu_exec_pkg::seq_run;
                end
            endcase
        end
    end

    // ***
    // State register
    // ***
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ***
    // Read data and outputs
    // ***
    // Read data is a mux of flops, so a read right after a write sees it.
    always_comb begin
        hrdata = 32'h0000_0000;
        if (st.phase.valid && !st.phase.write) begin
            unique case (st.phase.addr)
                `MAP_CMD: hrdata = st.last_cmd;
                `MAP_STATUS: begin
                    hrdata[`ST_CARRY] = st.carry_flag;
                    hrdata[`ST_HALF_CARRY] = st.half_carry_flag;
                    hrdata[`ST_ZERO] = st.zero_flag;
                    hrdata[`ST_TIME_OUT] = st.time_out_flag;
                    hrdata[`ST_POWER_DOWN] = st.power_down_flag;
                    hrdata[`ST_GIE] = st.global_interrupt_enable;
                    hrdata[`ST_BUSY] = (st.seq == mcu_exec_pkg::seq_pop);
                    hrdata[`ST_HALTED] = (st.seq == mcu_exec_pkg::seq_halt);
                end
                `MAP_WORKING: hrdata[7:0] = st.working_register;
                `MAP_PC: hrdata[PC_WIDTH-1:0] = st.pc;
                `MAP_WATCHDOG: begin
                    hrdata[7:0] = st.watchdog_counter;
                    hrdata[`WD_FIRST_SEEN] = st.first_seen;
                    hrdata[`WD_SECOND_SEEN] = st.second_seen;
                end
                `MAP_MEM_ADDR: hrdata[AW-1:0] = st.mem_addr;
                `MAP_MEM_DATA: hrdata[7:0] = st.dmem[st.mem_addr];
                `MAP_STACK: hrdata[PC_WIDTH-1:0] = st.stack[top];
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states and always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign working_register        = st.working_register;
    assign program_counter         = st.pc;
    assign global_interrupt_enable = st.global_interrupt_enable;
    assign power_down_flag         = st.power_down_flag;
    assign time_out_flag           = st.time_out_flag;
    assign clock_stopped           = (st.seq == mcu_exec_pkg::seq_halt);

endmodule
`default_nettype wire

/* File: logic/mcu_exec_map.svh */
// Offsets, field positions, reset values and counts of the execute block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
`ifndef MCU_EXEC_MAP_SVH
`define MCU_EXEC_MAP_SVH

// ***
// Register offsets
// ***
`define MAP_CMD          5'h00
`define MAP_STATUS       5'h04
`define MAP_WORKING      5'h08
`define MAP_PC           5'h0c
`define MAP_WATCHDOG     5'h10
`define MAP_MEM_ADDR     5'h14
`define MAP_MEM_DATA     5'h18
`define MAP_STACK        5'h1c

// ***
// Field positions
// ***
`define CMD_OP_LSB       0
`define CMD_MADDR_LSB    8
`define CMD_IMM_LSB      16
`define ST_CARRY         0
`define ST_HALF_CARRY    1
`define ST_ZERO          2
`define ST_TIME_OUT      3
`define ST_POWER_DOWN    4
`define ST_GIE           5
`define ST_BUSY          6
`define ST_HALTED        7
`define ST_WAKE          8
`define WD_FIRST_SEEN    8
`define WD_SECOND_SEEN   9

// ***
// Reset values and counts
// ***
`define RST_WORKING      8'h00
`define RST_WATCHDOG     8'h00
`define WATCHDOG_TOP     8'hff
`define WATCHDOG_PRESCALE_DEFAULT 256
`define BCD_LIMIT        5'h09
`define BCD_FIX          5'h06

`endif

/* File: logic/mcu_exec_pkg.sv */
// Types shared by the execute block and its arithmetic unit.
// Assumes nothing of its surroundings.
package mcu_exec_pkg;

    // Instruction codes, numbered 0 upward in this order.
    typedef enum logic [4:0] {
        op_nop, first_preclear_op, second_preclear_op,
        complement_in_place, complement_to_working, decimal_adjust_op,
        minus_one_op, minus_one_to_working, plus_one_op, plus_one_to_working,
        power_down_op, direct_branch_op, copy_mem_to_working,
        copy_imm_to_working, copy_working_to_mem, union_mem_to_working,
        union_imm_to_working, union_into_mem_op, pop_back_op,
        pop_back_imm_op, interrupt_exit_op, rotate_left_op,
        rotate_left_working, rotate_left_via_carry, rotate_left_via_carry_working
    } op_t;

    // Sequencer states.
    typedef enum logic [1:0] {seq_run, seq_pop, seq_halt} seq_t;

    // Result of one data operation.
    typedef struct packed {
        logic [7:0] value;
        logic       to_working;
        logic       to_mem;
        logic       set_zero;
        logic       set_carry;
        logic       carry;
    } exec_res_t;

    // Captured AHB address phase.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [4:0] addr;
    } bus_phase_t;

endpackage

/* File: sim/mcu_exec_sva.sv */
// Port checker of the execute block.
// Assumes binding into the core and commands spaced as the core expects.
`timescale 1ns/10ps
`default_nettype none
module mcu_exec_sva #(parameter int PC_WIDTH = 13) (
    input wire logic hclk, hresetn, hsel, hwrite, hready, clock_stopped,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0] htrans,
    input wire logic [7:0] working_register,
    input wire logic [PC_WIDTH-1:0] program_counter,
    input wire logic global_interrupt_enable, power_down_flag, time_out_flag
);
    logic       cw;
    logic [1:0] sn;
    wire logic [4:0] op = hwdata[4:0];
    wire logic go = cw && !clock_stopped;
    wire logic [PC_WIDTH-1:0] pc1 = program_counter + 1'b1;
    // Track command data phases; halted cycles are skipped because the core ignores them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) {cw, sn} <= 3'h0;
        else begin
            cw <= hsel && hready && htrans[1] && hwrite && haddr[4:0] == 5'h00;
            if (go && op inside {5'h01, 5'h02}) sn <= &(sn | op[1:0]) ? 2'h0 : sn | op[1:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_stop; go && op == 5'h0a |=> clock_stopped && program_counter == $past(pc1); endproperty
    a_stop: assert property (p_stop) else $error("halt entry wrong");
    property p_pdf; go && op == 5'h0a |=> power_down_flag && !time_out_flag; endproperty
    a_pdf: assert property (p_pdf) else $error("halt flags wrong");
    property p_jmp; go && op == 5'h0b |=> program_counter == $past(hwdata[16 +: PC_WIDTH]); endproperty
    a_jmp: assert property (p_jmp) else $error("branch wrong");
    property p_imm; go && op == 5'h0d |=> working_register == $past(hwdata[23:16]); endproperty
    a_imm: assert property (p_imm) else $error("constant load wrong");
    property p_nop; go && op == 5'h00
        |=> program_counter == $past(pc1) && $stable(working_register); endproperty
    a_nop: assert property (p_nop) else $error("idle step wrong");
    property p_rimm; go && op == 5'h13 |-> ##2 working_register == $past(hwdata[23:16], 2); endproperty
    a_rimm: assert property (p_rimm) else $error("return constant wrong");
    property p_gie; go && op == 5'h14 |-> ##2 global_interrupt_enable; endproperty
    a_gie: assert property (p_gie) else $error("enable not set");
    property p_clr; go && (op == 5'h01 && sn[1] || op == 5'h02 && sn[0])
        |=> !power_down_flag && !time_out_flag; endproperty
    a_clr: assert property (p_clr) else $error("preclear pair wrong");
    c_stop: cover property (go && op == 5'h0a);
    c_ret: cover property (go && op == 5'h12);
    c_clr: cover property (go && op == 5'h02 && sn[0]);
endmodule
bind mcu_exec_core mcu_exec_sva #(.PC_WIDTH(PC_WIDTH)) i_mcu_exec_sva (.hclk, .hresetn, .hsel,
    .hwrite, .hready, .clock_stopped, .haddr, .hwdata, .htrans, .working_register,
    .program_counter, .global_interrupt_enable, .power_down_flag, .time_out_flag);
`default_nettype wire

/* File: sim/prog_mem.sv */
// Program memory model: command words of the directed run.
// Assumes the bench steps the index a cycle before it uses the word.
`timescale 1ns/10ps
`default_nettype none
module prog_mem (
    input  wire logic [2:0]  idx,
    output logic      [31:0] word
);
    logic [31:0] rom[8] = '{32'h5a000d, 32'h123000b, 32'h0, 32'h14, 32'h330013, 32'h12, 32'ha, 32'h2};
    // A plain lookup; the model never stalls because the bench fetches words itself.
    assign word = rom[idx];
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Bench of the execute block: data ops against a reference, then control steps.
// Assumes the program memory model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rdp = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, word, v, rs = 32'h6ee8;
    logic [1:0] htrans = 2'b00;
    logic [2:0] s = 3'h0;
    logic [18:0] e;
    logic [63:0] q[$];
    int error_cnt = 0, checks = 0;
    logic [4:0] ops[16] = '{3, 4, 5, 6, 7, 8, 9, 12, 14, 15, 16, 17, 21, 22, 23, 24};
    logic [4:0] ra[8] = '{8, 12, 12, 4, 8, 12, 4, 4};
    logic [63:0] ex[8] = '{64'hff_0000005a, 64'h1fff_00000123, 64'h1fff_00000124, 64'h20_00000020,
        64'hff_00000033, 64'h1fff_00000456, 64'h98_00000090, 64'h18_00000000};
    always #2.5 hclk = ~hclk;
    mcu_exec_core #(.WATCHDOG_PRESCALE(4)) i_mcu_exec_core (.hclk, .hresetn, .hsel(1'b1), .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .working_register(), .program_counter(), .global_interrupt_enable(), .power_down_flag(),
        .time_out_flag(), .clock_stopped());
    prog_mem i_prog_mem (.idx(s), .word);
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // Reference: {zero, half carry, carry, memory, working} after one data op.
    function automatic logic [18:0] ref_op(logic [4:0] o, logic [7:0] w, m, x, logic [2:0] f);
        logic [7:0] r;
        logic c;
        logic [4:0] l, h;
        c = f[0];
        l = {1'b0, w[3:0]} + ((w[3:0] > 9 || f[1]) ? 5'h06 : 5'h00);
        h = {1'b0, w[7:4]} + l[4];
        if (o == 5 && (h > 9 || f[0])) begin h = h + 6; c = 1'b1; end
        case (o)
            3, 4: r = ~m;
            5: r = {h[3:0], l[3:0]};
            6, 7: r = m - 1;
            8, 9: r = m + 1;
            12: r = m;
            14: r = w;
            15, 17: r = w | m;
            16: r = w | x;
            21, 22: r = {m[6:0], m[7]};
            default: begin r = {m[6:0], f[0]}; c = m[7]; end
        endcase
        return {(o inside {5, 12, 14, 21, 22, 23, 24}) ? f[2] : r == 0, f[1], c,
            (o inside {3, 5, 6, 8, 14, 17, 21, 23}) ? {r, w} : {m, r}};
    endfunction
    task automatic report_and_stop;
        if (error_cnt == 0 && checks > 0 && q.size() == 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Waits for ready under a bound; a hang ends the run as a mismatch.
    task automatic hold;
        for (int n = 0; n < 9; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        error_cnt++;
        $display("mismatch %0t bus wait", $time);
        report_and_stop;
    endtask
    // One single transfer; a read files its {mask, expected} note for the monitor.
    task automatic bus(logic wr, logic [4:0] a, logic [31:0] d, logic [63:0] x);
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {27'h0, a};
        hold;
        htrans <= 2'b00;
        hwdata <= d;
        rdp <= !wr;
        if (!wr) q.push_back(x);
        hold;
        rdp <= 1'b0;
    endtask
    // Read data is taken at the edge that closes its data phase.
    always @(posedge hclk) begin
        if (rdp && q.size() > 0) begin
            checks++;
            if ((hrdata & q[0][63:32]) !== q[0][31:0] || hresp !== 1'b0) begin
                error_cnt++;
                $display("mismatch %0t read %h want %h", $time, hrdata, q[0][31:0]);
            end
            void'(q.pop_front());
        end
    end
    // Data ops on a boundary round then random rounds, then the program steps.
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, 5'h14, 32'h5, 64'h0);
        for (int r = 0; r < 48; r++) begin
            rs = xs(rs);
            v = rs;
            if (r < 16) v[15:0] = 16'hff00;
            e = ref_op(ops[r % 16], v[7:0], v[15:8], v[23:16], v[26:24]);
            bus(1'b1, 5'h18, {24'h0, v[15:8]}, 64'h0);
            bus(1'b1, 5'h08, {24'h0, v[7:0]}, 64'h0);
            bus(1'b1, 5'h04, {29'h0, v[26:24]}, 64'h0);
            bus(1'b1, 5'h00, {8'h0, v[23:16], 8'h05, 3'h0, ops[r % 16]}, 64'h0);
            bus(1'b0, 5'h08, 32'h0, {32'hff, 24'h0, e[7:0]});
            bus(1'b0, 5'h18, 32'h0, {32'hff, 24'h0, e[15:8]});
            bus(1'b0, 5'h04, 32'h0, {32'h7, 29'h0, e[18:16]});
        end
        bus(1'b1, 5'h1c, 32'h456, 64'h0);
        bus(1'b1, 5'h1c, 32'h10, 64'h0);
        bus(1'b1, 5'h1c, 32'h20, 64'h0);
        for (int k = 0; k < 8; k++) begin
            s <= k[2:0];
            @(posedge hclk);
            bus(1'b1, 5'h00, word, 64'h0);
            bus(1'b0, ra[k], 32'h0, ex[k]);
            if (k == 6) begin
                bus(1'b1, 5'h00, 32'h0, 64'h0);
                bus(1'b0, 5'h0c, 32'h0, 64'h1fff_00000457);
                bus(1'b1, 5'h04, 32'h110, 64'h0);
                bus(1'b1, 5'h00, 32'h1, 64'h0);
                bus(1'b0, 5'h04, 32'h0, 64'h18_00000010);
            end
        end
        @(posedge hclk);
        report_and_stop;
    end
endmodule
`default_nettype wire
